// ==== rtl/iasb_pkg.sv ====
// Purpose: Constants for the alarm status bank of the input/output module.
// Assumes: Sixteen-bit register words addressed by their printed offsets.
// Notes:   Masks keep reserved bit positions at zero.
`default_nettype none

package iasb_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] IASB_APP_STATUS_ADDR   = 16'h3927;
    localparam logic [15:0] IASB_APP_QUAL_ADDR     = 16'h3928;
    localparam logic [15:0] IASB_CRADLE_QUAL_ADDR  = 16'h3997;
    localparam logic [15:0] IASB_CRADLE_ADDR       = 16'h3998;
    localparam logic [15:0] IASB_MOTOR_QUAL_ADDR   = 16'h3999;
    localparam logic [15:0] IASB_MOTOR_ADDR        = 16'h399A;
    localparam logic [15:0] IASB_OTHER_QUAL_ADDR   = 16'h399B;
    localparam logic [15:0] IASB_OTHER_ADDR        = 16'h399C;
    localparam logic [15:0] IASB_INPUT_QUAL_ADDR   = 16'h399D;
    localparam logic [15:0] IASB_INPUT_ADDR        = 16'h399E;
    localparam logic [15:0] IASB_MISMATCH_QUAL_ADDR = 16'h399F;
    localparam logic [15:0] IASB_MISMATCH_ADDR     = 16'h39A0;
    localparam logic [15:0] IASB_RSVD_FIRST_ADDR   = 16'h39A1;
    localparam logic [15:0] IASB_RSVD_LAST_ADDR    = 16'h39A6;

    // ----------------------------------------------------------------
    // Defined bit masks
    // ----------------------------------------------------------------
    // Cradle word: bits 0 to 4 and bit 8.
    localparam logic [15:0] IASB_CRADLE_MASK   = 16'h011F;
    // Motor word: every bit reserved.
    localparam logic [15:0] IASB_MOTOR_MASK    = 16'h0000;
    // Other application word: bits 0 to 2.
    localparam logic [15:0] IASB_OTHER_MASK    = 16'h0007;
    // Predefined input word: bits 0 to 9.
    localparam logic [15:0] IASB_INPUT_MASK    = 16'h03FF;
    // Discrepancy word: bits 0 to 3.
    localparam logic [15:0] IASB_MISMATCH_MASK = 16'h000F;
    // Application status word: bit 0 only.
    localparam logic [15:0] IASB_APP_MASK      = 16'h0001;

    localparam logic [15:0] IASB_ZERO_WORD     = 16'h0000;

endpackage : iasb_pkg

`default_nettype wire

// ==== rtl/iasb_status_bank.sv ====
// Purpose: Read-only alarm status bank with per-bit quality words.
// Assumes: Alarm and validity words come from application logic on i_clk.
// Notes:   Reads answer one cycle later; writes are never stored.
`default_nettype none

module iasb_status_bank
    import iasb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_rd_en,
    input  wire logic        i_wr_en,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_cradle_alarm,
    input  wire logic [15:0] i_cradle_valid,
    input  wire logic [15:0] i_other_alarm,
    input  wire logic [15:0] i_other_valid,
    input  wire logic [15:0] i_input_alarm,
    input  wire logic [15:0] i_input_valid,
    input  wire logic [15:0] i_mismatch_alarm,
    input  wire logic [15:0] i_mismatch_valid,
    input  wire logic        i_app_enable,
    input  wire logic        i_app_valid,
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    output logic             o_rd_hit,
    output logic             o_wr_refused
);

    // ----------------------------------------------------------------
    // Status snapshots
    // ----------------------------------------------------------------
    logic [15:0] cradle_ff;
    logic [15:0] cradle_q_ff;
    logic [15:0] other_ff;
    logic [15:0] other_q_ff;
    logic [15:0] input_ff;
    logic [15:0] input_q_ff;
    logic [15:0] mismatch_ff;
    logic [15:0] mismatch_q_ff;
    logic [15:0] app_ff;
    logic [15:0] app_q_ff;

    wire  [15:0] nxt_cradle     = i_cradle_alarm & IASB_CRADLE_MASK;
    wire  [15:0] nxt_cradle_q   = i_cradle_valid & IASB_CRADLE_MASK;
    wire  [15:0] nxt_other      = i_other_alarm & IASB_OTHER_MASK;
    wire  [15:0] nxt_input      = i_input_alarm & IASB_INPUT_MASK;
    wire  [15:0] nxt_mismatch   = i_mismatch_alarm & IASB_MISMATCH_MASK;
    wire  [15:0] nxt_other_q    = i_other_valid & IASB_OTHER_MASK;
    wire  [15:0] nxt_input_q    = i_input_valid & IASB_INPUT_MASK;
    wire  [15:0] nxt_mismatch_q = i_mismatch_valid & IASB_MISMATCH_MASK;
    wire  [15:0] nxt_app        = {15'h0000, i_app_enable} & IASB_APP_MASK;
    wire  [15:0] nxt_app_q      = {15'h0000, i_app_valid} & IASB_APP_MASK;

    // Snapshots cost one cycle of latency but keep the read mux off the raw inputs.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cradle_ff     <= IASB_ZERO_WORD;
            cradle_q_ff   <= IASB_ZERO_WORD;
            other_ff      <= IASB_ZERO_WORD;
            other_q_ff    <= IASB_ZERO_WORD;
            input_ff      <= IASB_ZERO_WORD;
            input_q_ff    <= IASB_ZERO_WORD;
            mismatch_ff   <= IASB_ZERO_WORD;
            mismatch_q_ff <= IASB_ZERO_WORD;
            app_ff        <= IASB_ZERO_WORD;
            app_q_ff      <= IASB_ZERO_WORD;
        end else begin
            cradle_ff     <= nxt_cradle;
            cradle_q_ff   <= nxt_cradle_q;
            other_ff      <= nxt_other;
            other_q_ff    <= nxt_other_q;
            input_ff      <= nxt_input;
            input_q_ff    <= nxt_input_q;
            mismatch_ff   <= nxt_mismatch;
            mismatch_q_ff <= nxt_mismatch_q;
            app_ff        <= nxt_app;
            app_q_ff      <= nxt_app_q;
        end
    end

    // ----------------------------------------------------------------
    // Address decode and read selection
    // ----------------------------------------------------------------
    wire sel_app      = (i_addr == IASB_APP_STATUS_ADDR);
    wire sel_app_q    = (i_addr == IASB_APP_QUAL_ADDR);
    wire sel_cradle_q = (i_addr == IASB_CRADLE_QUAL_ADDR);
    wire sel_cradle   = (i_addr == IASB_CRADLE_ADDR);
    wire sel_motor_q  = (i_addr == IASB_MOTOR_QUAL_ADDR);
    wire sel_motor    = (i_addr == IASB_MOTOR_ADDR);
    wire sel_other_q  = (i_addr == IASB_OTHER_QUAL_ADDR);
    wire sel_other    = (i_addr == IASB_OTHER_ADDR);
    wire sel_input_q  = (i_addr == IASB_INPUT_QUAL_ADDR);
    wire sel_input    = (i_addr == IASB_INPUT_ADDR);
    wire sel_mism_q   = (i_addr == IASB_MISMATCH_QUAL_ADDR);
    wire sel_mism     = (i_addr == IASB_MISMATCH_ADDR);
    wire sel_rsvd     = (i_addr >= IASB_RSVD_FIRST_ADDR) && (i_addr <= IASB_RSVD_LAST_ADDR);

    wire bank_hit = sel_app | sel_app_q | sel_cradle_q | sel_cradle | sel_motor_q
                  | sel_motor | sel_other_q | sel_other | sel_input_q | sel_input
                  | sel_mism_q | sel_mism | sel_rsvd;

    // Motor words answer with no defined alarm.
    wire [15:0] motor_word = IASB_ZERO_WORD & IASB_MOTOR_MASK;

    // Reserved span and unknown addresses read zero.
    wire [15:0] rd_word =
          sel_app      ? app_ff
        : sel_app_q    ? app_q_ff
        : sel_cradle_q ? cradle_q_ff
        : sel_cradle   ? cradle_ff
        : sel_motor_q  ? motor_word
        : sel_motor    ? motor_word
        : sel_other_q  ? other_q_ff
        : sel_other    ? other_ff
        : sel_input_q  ? input_q_ff
        : sel_input    ? input_ff
        : sel_mism_q   ? mismatch_q_ff
        : sel_mism     ? mismatch_ff
        : IASB_ZERO_WORD;

    // ----------------------------------------------------------------
    // Read answer and write refusal
    // ----------------------------------------------------------------
    wire [15:0] nxt_rd_data    = i_rd_en ? rd_word : IASB_ZERO_WORD;
    wire        nxt_rd_hit     = i_rd_en & bank_hit;
    wire        nxt_wr_refused = i_wr_en & bank_hit;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rd_data    <= IASB_ZERO_WORD;
            o_rd_valid   <= 1'b0;
            o_rd_hit     <= 1'b0;
            o_wr_refused <= 1'b0;
        end else begin
            o_rd_data    <= nxt_rd_data;
            o_rd_valid   <= i_rd_en;
            o_rd_hit     <= nxt_rd_hit;
            o_wr_refused <= nxt_wr_refused;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Two cycles out of reset before the snapshots reflect live inputs.
    logic [1:0] arm_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            arm_ff <= 2'h0;
        end else begin
            arm_ff <= {arm_ff[0], 1'b1};
        end
    end
    wire armed = arm_ff[1];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_cradle_quality;
        armed && i_rd_en && i_addr == IASB_CRADLE_QUAL_ADDR |=>
            o_rd_data == ($past(i_cradle_valid, 2) & IASB_CRADLE_MASK);
    endproperty
    a_cradle_quality: assert property (p_cradle_quality)
        else $error("Cradle quality word wrong.");

    property p_cradle_low;
        armed && i_rd_en && i_addr == IASB_CRADLE_ADDR |=>
            o_rd_data[2:0] == $past(i_cradle_alarm[2:0], 2);
    endproperty
    a_cradle_low: assert property (p_cradle_low)
        else $error("Cradle alarm bits 0-2 wrong.");

    property p_cradle_high;
        armed && i_rd_en && i_addr == IASB_CRADLE_ADDR |=>
            o_rd_data[8] == $past(i_cradle_alarm[8], 2) && o_rd_data[15:9] == 7'h00
            && o_rd_data[7:5] == 3'h0 && o_rd_data[4:3] == $past(i_cradle_alarm[4:3], 2);
    endproperty
    a_cradle_high: assert property (p_cradle_high)
        else $error("Cradle alarm upper bits wrong.");

    property p_motor;
        i_rd_en && (i_addr == IASB_MOTOR_ADDR || i_addr == IASB_MOTOR_QUAL_ADDR) |=>
            o_rd_hit && o_rd_data == 16'h0000;
    endproperty
    a_motor: assert property (p_motor)
        else $error("Motor word not zero.");

    property p_other_contactor;
        armed && i_rd_en && i_addr == IASB_OTHER_ADDR |=>
            o_rd_data[1:0] == $past(i_other_alarm[1:0], 2);
    endproperty
    a_other_contactor: assert property (p_other_contactor)
        else $error("Contactor alarm bits wrong.");

    property p_other_energy;
        armed && i_rd_en && i_addr == IASB_OTHER_ADDR |=>
            o_rd_data[2] == $past(i_other_alarm[2], 2) && o_rd_data[15:3] == 13'h0000;
    endproperty
    a_other_energy: assert property (p_other_energy)
        else $error("Energy reduction bit wrong.");

    property p_input_low;
        armed && i_rd_en && i_addr == IASB_INPUT_ADDR |=>
            o_rd_data[3:0] == $past(i_input_alarm[3:0], 2);
    endproperty
    a_input_low: assert property (p_input_low)
        else $error("Input alarm bits 0-3 wrong.");

    property p_input_high;
        armed && i_rd_en && i_addr == IASB_INPUT_ADDR |=>
            o_rd_data[9:4] == $past(i_input_alarm[9:4], 2) && o_rd_data[15:10] == 6'h00;
    endproperty
    a_input_high: assert property (p_input_high)
        else $error("Input alarm bits 4-15 wrong.");

    property p_mismatch;
        armed && i_rd_en && i_addr == IASB_MISMATCH_ADDR |=>
            o_rd_data == {12'h000, $past(i_mismatch_alarm[3:0], 2)};
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("Discrepancy word wrong.");

    property p_pair_quality;
        armed && i_rd_en && i_addr == IASB_INPUT_QUAL_ADDR |=>
            o_rd_data == ($past(i_input_valid, 2) & IASB_INPUT_MASK);
    endproperty
    a_pair_quality: assert property (p_pair_quality)
        else $error("Input quality word wrong.");

    property p_app_status;
        armed && i_rd_en && i_addr == IASB_APP_STATUS_ADDR |=>
            o_rd_data == {15'h0000, $past(i_app_enable, 2)};
    endproperty
    a_app_status: assert property (p_app_status)
        else $error("Application status word wrong.");

    property p_app_quality;
        armed && i_rd_en && i_addr == IASB_APP_QUAL_ADDR |=>
            o_rd_data == {15'h0000, $past(i_app_valid, 2)};
    endproperty
    a_app_quality: assert property (p_app_quality)
        else $error("Application quality word wrong.");

    property p_reserved;
        i_rd_en && i_addr >= IASB_RSVD_FIRST_ADDR && i_addr <= IASB_RSVD_LAST_ADDR |=>
            o_rd_valid && o_rd_hit && o_rd_data == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved span not zero.");

    property p_other_quality;
        armed && i_rd_en && i_addr == IASB_OTHER_QUAL_ADDR |=>
            o_rd_data == ($past(i_other_valid, 2) & IASB_OTHER_MASK);
    endproperty
    a_other_quality: assert property (p_other_quality)
        else $error("Other quality word wrong.");

    property p_mism_quality;
        armed && i_rd_en && i_addr == IASB_MISMATCH_QUAL_ADDR |=>
            o_rd_data == ($past(i_mismatch_valid, 2) & IASB_MISMATCH_MASK);
    endproperty
    a_mism_quality: assert property (p_mism_quality)
        else $error("Discrepancy quality word wrong.");

    property p_write_refused;
        i_wr_en && (i_addr == IASB_CRADLE_ADDR || i_addr == IASB_OTHER_ADDR) |=>
            o_wr_refused;
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("Bank write not flagged.");

    property p_write_foreign;
        i_wr_en && i_addr < IASB_APP_STATUS_ADDR |=> !o_wr_refused;
    endproperty
    a_write_foreign: assert property (p_write_foreign)
        else $error("Foreign write flagged.");

    property p_unknown_read;
        i_rd_en && (i_addr < IASB_APP_STATUS_ADDR || i_addr > IASB_RSVD_LAST_ADDR) |=>
            o_rd_valid && !o_rd_hit && o_rd_data == IASB_ZERO_WORD;
    endproperty
    a_unknown_read: assert property (p_unknown_read)
        else $error("Unknown address answered.");

    // Idle outputs stay quiet.
    property p_idle_quiet;
        !i_rd_en |=> !o_rd_valid && !o_rd_hit && o_rd_data == IASB_ZERO_WORD;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Read outputs active with no read.");

    // Answer stands exactly one cycle.
    property p_answer_timing;
        i_rd_en |=> o_rd_valid ##1 (o_rd_valid == $past(i_rd_en));
    endproperty
    a_answer_timing: assert property (p_answer_timing)
        else $error("Read answer timing wrong.");

    c_cradle_alarm: cover property (armed && i_rd_en && i_addr == IASB_CRADLE_ADDR
                                    ##1 o_rd_data != 16'h0000);
    c_write_refused: cover property (i_wr_en && i_addr == IASB_CRADLE_ADDR ##1 o_wr_refused);
    c_back_to_back: cover property (i_rd_en [*3] ##1 o_rd_valid);

endmodule // iasb_status_bank

`default_nettype wire

// ==== bench/iasb_client_model.sv ====
// Purpose: Remote register client that reads and writes the alarm status bank.
// Assumes: One request at a time, launched just after a rising edge.
// Notes:   The answer is sampled after its edge settles; the address is scrambled when idle.
`default_nettype none

module iasb_client_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    input  wire logic        i_rd_hit,
    input  wire logic        i_wr_refused,
    output logic             o_rd_en,
    output logic             o_wr_en,
    output logic      [15:0] o_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_rd_en = 1'b0;
        o_wr_en = 1'b0;
        o_addr  = 16'h0000;
    end

    // One request taken at the next edge; its answer stands for exactly one cycle.
    task automatic access(input logic wr, input logic [15:0] addr, output logic [15:0] data,
                          output logic valid, output logic hit, output logic refused);
        @(posedge i_clk);
        o_rd_en <= ~wr;
        o_wr_en <= wr;
        o_addr  <= addr;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_wr_en <= 1'b0;
        o_addr  <= ~addr;
        #1;
        data    = i_rd_data;
        valid   = i_rd_valid;
        hit     = i_rd_hit;
        refused = i_wr_refused;
    endtask
endmodule // iasb_client_model

`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the alarm status bank.
// Assumes: Status inputs are steady two edges before each read.
// Notes:   Expected words come from the bit maps, never from the design.
`default_nettype none

module tb_top
    import iasb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [15:0] cr_a, cr_v, ot_a, ot_v, in_a, in_v, mm_a, mm_v;
    logic        app_en;
    logic        app_val;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_hit;
    logic        wr_refused;
    int          failures;
    int          samples_checked;

    localparam logic [15:0] MAP_ADDR [12] = '{16'h3927, 16'h3928, 16'h3997, 16'h3998,
        16'h3999, 16'h399A, 16'h399B, 16'h399C, 16'h399D, 16'h399E, 16'h399F, 16'h39A0};
    localparam logic [15:0] MAP_MASK [12] = '{16'h0001, 16'h0001, 16'h011F, 16'h011F,
        16'h0000, 16'h0000, 16'h0007, 16'h0007, 16'h03FF, 16'h03FF, 16'h000F, 16'h000F};

    iasb_status_bank u_iasb_status_bank (.i_clk(clk), .i_rst_n(rst_n), .i_rd_en(rd_en),
        .i_wr_en(wr_en), .i_addr(addr), .i_cradle_alarm(cr_a), .i_cradle_valid(cr_v),
        .i_other_alarm(ot_a), .i_other_valid(ot_v), .i_input_alarm(in_a),
        .i_input_valid(in_v), .i_mismatch_alarm(mm_a), .i_mismatch_valid(mm_v),
        .i_app_enable(app_en), .i_app_valid(app_val), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_rd_hit(rd_hit), .o_wr_refused(wr_refused));

    iasb_client_model u_iasb_client_model (.i_clk(clk), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .i_rd_hit(rd_hit), .i_wr_refused(wr_refused),
        .o_rd_en(rd_en), .o_wr_en(wr_en), .o_addr(addr));

    // ----------------------------------------------------------------
    // Compare and closing tasks
    // ----------------------------------------------------------------
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Each word gets its own pattern so that swapped words cannot pass.
    function automatic logic [15:0] word_val(input logic [15:0] p, input int k);
        return p ^ (16'h1111 * k[15:0]);
    endfunction

    task automatic set_inputs(input logic [15:0] p);
        @(posedge clk);
        cr_a    <= word_val(p, 1);
        cr_v    <= ~word_val(p, 1);
        ot_a    <= word_val(p, 3);
        ot_v    <= ~word_val(p, 3);
        in_a    <= word_val(p, 4);
        in_v    <= ~word_val(p, 4);
        mm_a    <= word_val(p, 5);
        mm_v    <= ~word_val(p, 5);
        app_en  <= p[0];
        app_val <= ~p[0];
        repeat (2) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_bank_map(input logic [15:0] p);
        logic [15:0] d;
        logic [15:0] v;
        logic        vl, h, r, isq;
        set_inputs(p);
        for (int i = 0; i < 12; i++) begin
            isq = (i == 1) || (i >= 2 && i % 2 == 0);
            v   = word_val(p, i / 2);
            u_iasb_client_model.access(1'b0, MAP_ADDR[i], d, vl, h, r);
            check_word("map read data", (isq ? ~v : v) & MAP_MASK[i], d);
            check_bit("map read valid", 1'b1, vl);
            check_bit("map read hit", 1'b1, h);
        end
    endtask

    task automatic t_reserved_span();
        logic [15:0] d;
        logic        vl, h, r;
        set_inputs(16'hFFFF);
        for (int a = 16'h39A1; a <= 16'h39A7; a++) begin
            u_iasb_client_model.access(1'b0, a[15:0], d, vl, h, r);
            check_word("reserved read data", 16'h0000, d);
            check_bit("reserved read hit", a != 16'h39A7, h);
        end
    endtask

    task automatic t_writes_ignored();
        logic [15:0] d;
        logic        vl, h, r;
        set_inputs(16'h00FF);
        u_iasb_client_model.access(1'b1, 16'h399C, d, vl, h, r);
        check_bit("write refused", 1'b1, r);
        check_bit("valid on write", 1'b0, vl);
        u_iasb_client_model.access(1'b1, 16'h1234, d, vl, h, r);
        check_bit("foreign write refused", 1'b0, r);
        u_iasb_client_model.access(1'b0, 16'h399C, d, vl, h, r);
        check_word("read after write", word_val(16'h00FF, 3) & 16'h0007, d);
    endtask

    // A reset in mid-run clears the answer; live values return once it is released.
    task automatic t_reset_midrun();
        logic [15:0] d;
        logic        vl, h, r;
        set_inputs(16'hFFFF);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_word("reset read data", 16'h0000, rd_data);
        check_bit("reset read valid", 1'b0, rd_valid);
        @(posedge clk);
        rst_n <= 1'b1;
        u_iasb_client_model.access(1'b0, IASB_CRADLE_ADDR, d, vl, h, r);
        check_word("cradle after reset", word_val(16'hFFFF, 1) & IASB_CRADLE_MASK, d);
        check_bit("valid after reset", 1'b1, vl);
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        failures        = 0;
        samples_checked = 0;
        rst_n           = 1'b0;
        {cr_a, cr_v, ot_a, ot_v, in_a, in_v, mm_a, mm_v} = '0;
        app_en          = 1'b0;
        app_val         = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_bank_map(16'hA5A5);
        t_bank_map(16'h5A5A);
        t_bank_map(16'hFFFF);
        t_bank_map(16'h0000);
        t_reserved_span();
        t_writes_ignored();
        t_reset_midrun();
        give_verdict();
    end

    // A hang would stall far beyond the roughly 150 cycles the scenarios need.
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
